// ===== pkg/gpio_pkg.sv
// Constants shared by the general-purpose port block.
package gpio_pkg;
    // Register offsets on the special-function register port.
    localparam logic [7:0] PORT0_DIRECTION_ADDR     = 8'hB8;
    localparam logic [7:0] EDGE_SELECT_REGISTER_ADDR = 8'hBF;
    localparam logic [7:0] PORT1_DIRECTION_ADDR     = 8'hC1;
    localparam logic [7:0] PORT2_DIRECTION_ADDR     = 8'hC2;
    localparam logic [7:0] PORT5_DIRECTION_ADDR     = 8'hC5;
    localparam logic [7:0] IRQ_STATUS_ADDR          = 8'hC8;
    localparam logic [7:0] IRQ_MASK_ADDR            = 8'hC9;
    localparam logic [7:0] PORT0_PIN_DATA_ADDR      = 8'hD0;
    localparam logic [7:0] PORT1_PIN_DATA_ADDR      = 8'hD1;
    localparam logic [7:0] PORT2_PIN_DATA_ADDR      = 8'hD2;
    localparam logic [7:0] PORT5_PIN_DATA_ADDR      = 8'hD5;
    localparam logic [7:0] PORT0_PULLUP_ADDR        = 8'hE0;
    localparam logic [7:0] PORT1_PULLUP_ADDR        = 8'hE1;
    localparam logic [7:0] PORT2_PULLUP_ADDR        = 8'hE2;
    localparam logic [7:0] PORT5_PULLUP_ADDR        = 8'hE5;
    localparam logic [7:0] DRAIN_MODE_CONTROL_ADDR  = 8'hE9;

    // Implemented bit positions of each port byte.
    localparam logic [7:0] PORT0_MASK      = 8'h01;
    localparam logic [7:0] PORT1_CFG_MASK  = 8'h0D;
    localparam logic [7:0] PORT1_READ_MASK = 8'h0F;
    localparam logic [7:0] PORT2_MASK      = 8'h3F;
    localparam logic [7:0] PORT5_MASK      = 8'h10;

    // Pin numbering of the flat twelve-pin vectors.
    localparam int PIN_COUNT        = 12;
    localparam int PORT0_PIN0       = 0;
    localparam int DRAIN_CAPABLE_PIN = 1;
    localparam int INPUT_ONLY_PIN   = 2;
    localparam int CRYSTAL_OUTPUT   = 3;
    localparam int CRYSTAL_INPUT    = 4;
    localparam int PORT2_BASE       = 5;
    localparam int PORT5_PIN4       = 11;

    // Field positions.
    localparam int DRAIN_ENABLE_BIT   = 0;
    localparam int RESET_SHARED_BIT   = 1;
    localparam int EDGE_FIELD_LSB     = 3;
    localparam int EXT_INT_FLAG_BIT   = 0;
    localparam int BASIC_TIMER_FLAG_BIT = 4;
    localparam int PWM_TIMER_FLAG_BIT = 5;
    localparam logic [7:0] IRQ_IMPL_MASK = 8'h31;

    typedef enum logic [1:0] {
        EDGE_RESERVED = 2'b00,
        EDGE_RISING   = 2'b01,
        EDGE_FALLING  = 2'b10,
        EDGE_BOTH     = 2'b11
    } edge_e;

    // Values after reset.
    localparam edge_e      EDGE_RESET = EDGE_FALLING;
    localparam logic [7:0] BYTE_RESET = 8'h00;
endpackage

// ===== core/gpio_ports.sv
// Twelve-pin general-purpose port block with open-drain and shared functions.
module gpio_ports (
    // Clock and reset.
    input  wire logic        clk_sys_i,
    input  wire logic        rstn_i,
    // Register port.
    input  wire logic [7:0]  addr_i,
    input  wire logic [7:0]  wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [7:0]  rdata_o,
    // Pins.
    input  wire logic [11:0] pin_in_i,
    output logic      [11:0] pin_out_o,
    output logic      [11:0] pin_oe_o,
    output logic      [11:0] pin_pullup_o,
    // Configuration options, held static by the system.
    input  wire logic        ext_reset_sel_i,
    input  wire logic        crystal_sel_i,
    // Timer side, on this clock.
    input  wire logic        basic_timer_ovf_i,
    input  wire logic        pwm_timer_ovf_i,
    input  wire logic        pwm_timer_enable_i,
    input  wire logic        pwm_output_select_i,
    input  wire logic        toggle_output_select_i,
    input  wire logic        pwm_wave_i,
    input  wire logic        buzzer_wave_i,
    // Interrupt.
    output logic             external_interrupt_input_o,
    output logic             irq_o
);

    typedef struct packed {
        logic [11:0]          pin_meta;
        logic [11:0]          pin_sync;
        logic                 int_prev;
        logic [1:0]           opt_meta;
        logic [1:0]           opt_sync;
        logic [11:0]          port_direction_bits;
        logic [11:0]          port_pullup_bits;
        logic [11:0]          latch;
        logic                 drain_enable_bit;
        gpio_pkg::edge_e      edge_select_field;
        logic [7:0]           status;
        logic [7:0]           mask;
        logic [7:0]           rdata;
    } state_s;

    state_s state_reg;
    state_s state_next;

    logic       ext_reset_sel;
    logic       crystal_sel;
    logic       ext_int_enable;
    logic       rise;
    logic       fall;
    logic       edge_hit;
    logic       pwm_sel;
    logic       buzzer_sel;
    logic [7:0] irq_events;
    logic [11:0] read_view;

    assign ext_reset_sel  = state_reg.opt_sync[0];
    assign crystal_sel    = state_reg.opt_sync[1];
    assign ext_int_enable = state_reg.mask[gpio_pkg::EXT_INT_FLAG_BIT];

    // The edge detector looks only at the second synchroniser stage, never the first.
    assign rise = state_reg.pin_sync[gpio_pkg::PORT0_PIN0] & ~state_reg.int_prev;
    assign fall = ~state_reg.pin_sync[gpio_pkg::PORT0_PIN0] & state_reg.int_prev;

    always_comb begin
        case (state_reg.edge_select_field)
            gpio_pkg::EDGE_RISING:  edge_hit = rise;
            gpio_pkg::EDGE_FALLING: edge_hit = fall;
            gpio_pkg::EDGE_BOTH:    edge_hit = rise | fall;
            default:                edge_hit = 1'b0;
        endcase
    end

    // Flags are raised whatever the mask holds; the mask gates irq_o, and mask bit 0 also enables the external interrupt input.
    always_comb begin
        irq_events = 8'h00;
        irq_events[gpio_pkg::EXT_INT_FLAG_BIT]     = edge_hit;
        irq_events[gpio_pkg::BASIC_TIMER_FLAG_BIT] = basic_timer_ovf_i;
        irq_events[gpio_pkg::PWM_TIMER_FLAG_BIT]   = pwm_timer_ovf_i;
    end

    assign pwm_sel    = pwm_timer_enable_i & pwm_output_select_i;
    assign buzzer_sel = pwm_timer_enable_i & toggle_output_select_i & ~pwm_output_select_i;

    // Input pins read their level, except pin 2 which reads one while ext_reset_sel is set; output pins read back the latch.
    always_comb begin
        for (int i = 0; i < gpio_pkg::PIN_COUNT; i++) begin
            read_view[i] = state_reg.port_direction_bits[i] ? state_reg.latch[i]
                                                            : state_reg.pin_sync[i];
        end
        if (ext_reset_sel) begin
            read_view[gpio_pkg::INPUT_ONLY_PIN] = 1'b1;
        end
    end

    always_comb begin
        state_next          = state_reg;
        state_next.pin_meta = pin_in_i;
        state_next.pin_sync = state_reg.pin_meta;
        state_next.int_prev = state_reg.pin_sync[gpio_pkg::PORT0_PIN0];
        state_next.opt_meta = {crystal_sel_i, ext_reset_sel_i};
        state_next.opt_sync = state_reg.opt_meta;
        state_next.rdata    = 8'h00;

        if (wr_i) begin
            case (addr_i)
                gpio_pkg::PORT0_DIRECTION_ADDR: begin
                    state_next.port_direction_bits[0] = wdata_i[0];
                end
                gpio_pkg::PORT1_DIRECTION_ADDR: begin
                    state_next.port_direction_bits[1] = wdata_i[0];
                    state_next.port_direction_bits[4:3] = wdata_i[3:2];
                end
                gpio_pkg::PORT2_DIRECTION_ADDR: begin
                    state_next.port_direction_bits[10:5] = wdata_i[5:0];
                end
                gpio_pkg::PORT5_DIRECTION_ADDR: begin
                    state_next.port_direction_bits[11] = wdata_i[4];
                end
                gpio_pkg::PORT0_PIN_DATA_ADDR: begin
                    state_next.latch[0] = wdata_i[0];
                end
                gpio_pkg::PORT1_PIN_DATA_ADDR: begin
                    state_next.latch[1] = wdata_i[0];
                    state_next.latch[4:3] = wdata_i[3:2];
                end
                gpio_pkg::PORT2_PIN_DATA_ADDR: begin
                    state_next.latch[10:5] = wdata_i[5:0];
                end
                gpio_pkg::PORT5_PIN_DATA_ADDR: begin
                    state_next.latch[11] = wdata_i[4];
                end
                gpio_pkg::PORT0_PULLUP_ADDR: begin
                    state_next.port_pullup_bits[0] = wdata_i[0];
                end
                gpio_pkg::PORT1_PULLUP_ADDR: begin
                    state_next.port_pullup_bits[1] = wdata_i[0];
                    state_next.port_pullup_bits[4:3] = wdata_i[3:2];
                end
                gpio_pkg::PORT2_PULLUP_ADDR: begin
                    state_next.port_pullup_bits[10:5] = wdata_i[5:0];
                end
                gpio_pkg::PORT5_PULLUP_ADDR: begin
                    state_next.port_pullup_bits[11] = wdata_i[4];
                end
                gpio_pkg::DRAIN_MODE_CONTROL_ADDR: begin
                    // Whole-byte write only; there is no read-back to merge with.
                    state_next.drain_enable_bit = wdata_i[gpio_pkg::DRAIN_ENABLE_BIT];
                end
                gpio_pkg::EDGE_SELECT_REGISTER_ADDR: begin
                    state_next.edge_select_field =
                        gpio_pkg::edge_e'(wdata_i[gpio_pkg::EDGE_FIELD_LSB +: 2]);
                end
                gpio_pkg::IRQ_STATUS_ADDR: begin
                    state_next.status = state_reg.status & ~(wdata_i & gpio_pkg::IRQ_IMPL_MASK);
                end
                gpio_pkg::IRQ_MASK_ADDR: begin
                    state_next.mask = wdata_i & gpio_pkg::IRQ_IMPL_MASK;
                end
                default: begin
                    state_next.mask = state_reg.mask;
                end
            endcase
        end

        // A new event outranks a clear written in the same cycle.
        state_next.status = state_next.status | irq_events;

        if (rd_i) begin
            case (addr_i)
                gpio_pkg::PORT0_DIRECTION_ADDR: begin
                    state_next.rdata = {7'h00, state_reg.port_direction_bits[0]};
                end
                gpio_pkg::PORT1_DIRECTION_ADDR: begin
                    state_next.rdata = {4'h0, state_reg.port_direction_bits[4:3], 1'b0,
                                        state_reg.port_direction_bits[1]};
                end
                gpio_pkg::PORT2_DIRECTION_ADDR: begin
                    state_next.rdata = {2'h0, state_reg.port_direction_bits[10:5]};
                end
                gpio_pkg::PORT5_DIRECTION_ADDR: begin
                    state_next.rdata = {3'h0, state_reg.port_direction_bits[11], 4'h0};
                end
                gpio_pkg::PORT0_PIN_DATA_ADDR: begin
                    state_next.rdata = {7'h00, read_view[0]} & gpio_pkg::PORT0_MASK;
                end
                gpio_pkg::PORT1_PIN_DATA_ADDR: begin
                    state_next.rdata = {4'h0, read_view[4:1]} & gpio_pkg::PORT1_READ_MASK;
                end
                gpio_pkg::PORT2_PIN_DATA_ADDR: begin
                    state_next.rdata = {2'h0, read_view[10:5]} & gpio_pkg::PORT2_MASK;
                end
                gpio_pkg::PORT5_PIN_DATA_ADDR: begin
                    state_next.rdata = {3'h0, read_view[11], 4'h0} & gpio_pkg::PORT5_MASK;
                end
                gpio_pkg::EDGE_SELECT_REGISTER_ADDR: begin
                    state_next.rdata = {3'h0, state_reg.edge_select_field, 3'h0};
                end
                gpio_pkg::IRQ_STATUS_ADDR: begin
                    state_next.rdata = state_reg.status;
                end
                gpio_pkg::IRQ_MASK_ADDR: begin
                    state_next.rdata = state_reg.mask;
                end
                // Pull-up and drain control are write-only and read as zero.
                default: begin
                    state_next.rdata = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_reg                   <= '0;
            state_reg.edge_select_field <= gpio_pkg::EDGE_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // Pin drivers.
    always_comb begin
        for (int i = 0; i < gpio_pkg::PIN_COUNT; i++) begin
            pin_out_o[i]    = state_reg.latch[i];
            pin_oe_o[i]     = state_reg.port_direction_bits[i];
            // A pin set as output never gets its pull-up.
            pin_pullup_o[i] = state_reg.port_pullup_bits[i]
                              & ~state_reg.port_direction_bits[i];
        end
        // Open drain sinks a low and lets the board pull a high.
        if (state_reg.drain_enable_bit && state_reg.port_direction_bits[1]) begin
            pin_out_o[gpio_pkg::DRAIN_CAPABLE_PIN] = 1'b0;
            pin_oe_o[gpio_pkg::DRAIN_CAPABLE_PIN]  = ~state_reg.latch[1];
        end
        pin_out_o[gpio_pkg::INPUT_ONLY_PIN]    = 1'b0;
        pin_oe_o[gpio_pkg::INPUT_ONLY_PIN]     = 1'b0;
        pin_pullup_o[gpio_pkg::INPUT_ONLY_PIN] = 1'b0;
        if (ext_int_enable) begin
            pin_oe_o[gpio_pkg::PORT0_PIN0] = 1'b0;
        end
        if (crystal_sel) begin
            pin_oe_o[4:3]     = 2'b00;
            pin_pullup_o[4:3] = 2'b00;
        end
        if (pwm_sel || buzzer_sel) begin
            pin_out_o[gpio_pkg::PORT5_PIN4]    = pwm_sel ? pwm_wave_i : buzzer_wave_i;
            pin_oe_o[gpio_pkg::PORT5_PIN4]     = 1'b1;
            pin_pullup_o[gpio_pkg::PORT5_PIN4] = 1'b0;
        end
    end

    assign external_interrupt_input_o = ext_int_enable
                                        & state_reg.pin_sync[gpio_pkg::PORT0_PIN0];
    assign irq_o   = |(state_reg.status & state_reg.mask);
    assign rdata_o = state_reg.rdata;

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rstn_i);

    dir_write_a: assert property (
        wr_i && addr_i == gpio_pkg::PORT2_DIRECTION_ADDR
        |=> pin_oe_o[10:5] == $past(wdata_i[5:0]))
        else $error("Port 2 direction write did not reach the drivers.");

    pullup_write_a: assert property (
        wr_i && addr_i == gpio_pkg::PORT2_PULLUP_ADDR && !(wr_i && addr_i == 8'hC2)
        ##1 !(wr_i && addr_i == gpio_pkg::PORT2_DIRECTION_ADDR)
        |-> pin_pullup_o[10:5] == ($past(wdata_i[5:0]) & ~pin_oe_o[10:5]))
        else $error("Port 2 pull-up write did not take effect.");

    pullup_output_a: assert property (
        (pin_pullup_o & state_reg.port_direction_bits) == 12'h000)
        else $error("Pull-up applied on an output pin.");

    input_only_a: assert property (
        !pin_oe_o[2] && !pin_pullup_o[2])
        else $error("Input-only pin driven or pulled up.");

    reset_read_a: assert property (
        rd_i && addr_i == gpio_pkg::PORT1_PIN_DATA_ADDR && ext_reset_sel
        |=> rdata_o[1])
        else $error("Reset-shared bit did not read one.");

    drain_low_a: assert property (
        wr_i && addr_i == gpio_pkg::DRAIN_MODE_CONTROL_ADDR && wdata_i[0]
        && state_reg.port_direction_bits[1]
        && !(wr_i && addr_i != gpio_pkg::DRAIN_MODE_CONTROL_ADDR)
        |=> !pin_out_o[1] && pin_oe_o[1] == !state_reg.latch[1])
        else $error("Open-drain pin drove a high level.");

    drain_off_a: assert property (
        !state_reg.drain_enable_bit
        |-> pin_oe_o[1] == state_reg.port_direction_bits[1] && pin_out_o[1] == state_reg.latch[1])
        else $error("Drain pin not push-pull with drain disabled.");

    drain_read_a: assert property (
        rd_i && addr_i == gpio_pkg::DRAIN_MODE_CONTROL_ADDR |=> rdata_o == 8'h00)
        else $error("Drain control register was readable.");

    unimpl_bits_a: assert property (
        rd_i && addr_i == gpio_pkg::PORT0_DIRECTION_ADDR |=> rdata_o[7:1] == 7'h00)
        else $error("Unimplemented port bits read non-zero.");

    pwm_route_a: assert property (
        pwm_timer_enable_i && pwm_output_select_i
        |-> pin_oe_o[11] && pin_out_o[11] == pwm_wave_i)
        else $error("PWM not routed to port 5 pin 4.");

    flag_set_a: assert property (
        basic_timer_ovf_i |=> state_reg.status[gpio_pkg::BASIC_TIMER_FLAG_BIT] [*2]
        or (wr_i && addr_i == gpio_pkg::IRQ_STATUS_ADDR))
        else $error("Timer flag not set by its event.");

    edge_rise_a: assert property (
        state_reg.edge_select_field == gpio_pkg::EDGE_RISING && rise
        |=> state_reg.status[gpio_pkg::EXT_INT_FLAG_BIT])
        else $error("Rising edge did not set the external flag.");

    pin_read_a: assert property (
        rd_i && addr_i == gpio_pkg::PORT2_PIN_DATA_ADDR && state_reg.port_direction_bits[10:5] == 6'h00
        |=> rdata_o[5:0] == $past(state_reg.pin_sync[10:5]))
        else $error("Port 2 read did not return pin levels.");

    // The buzzer only wins the pin while the wave output is off.
    buzzer_route_a: assert property (
        pwm_timer_enable_i && toggle_output_select_i && !pwm_output_select_i
        |-> pin_oe_o[gpio_pkg::PORT5_PIN4] && pin_out_o[gpio_pkg::PORT5_PIN4] == buzzer_wave_i)
        else $error("Buzzer not routed to port 5 pin 4.");

    ext_int_take_a: assert property (
        ext_int_enable |-> !pin_oe_o[gpio_pkg::PORT0_PIN0])
        else $error("Interrupt pin still driven while its input is enabled.");

    drain_write_a: assert property (
        wr_i && addr_i == gpio_pkg::DRAIN_MODE_CONTROL_ADDR
        |=> state_reg.drain_enable_bit == $past(wdata_i[gpio_pkg::DRAIN_ENABLE_BIT]))
        else $error("Drain control write did not land.");

    // A clear with no event beside it must really drop the flag.
    flag_clear_a: assert property (
        wr_i && addr_i == gpio_pkg::IRQ_STATUS_ADDR && wdata_i[gpio_pkg::PWM_TIMER_FLAG_BIT]
        && !pwm_timer_ovf_i
        |=> !state_reg.status[gpio_pkg::PWM_TIMER_FLAG_BIT])
        else $error("Writing one did not clear the timer flag.");

    edge_fall_a: assert property (
        state_reg.edge_select_field == gpio_pkg::EDGE_FALLING && fall
        |=> state_reg.status[gpio_pkg::EXT_INT_FLAG_BIT])
        else $error("Falling edge did not set the external flag.");

    // The reserved code must never raise the flag, whatever the pin does.
    edge_none_a: assert property (
        state_reg.edge_select_field == gpio_pkg::EDGE_RESERVED
        && !state_reg.status[gpio_pkg::EXT_INT_FLAG_BIT]
        |=> !state_reg.status[gpio_pkg::EXT_INT_FLAG_BIT])
        else $error("Reserved edge code raised the external flag.");

endmodule // gpio_ports

// ===== sim/pin_board_model.sv
// Board model of the pins: external drivers, internal pull-ups and the drain pin resistor.
module pin_board_model (
    // Clock.
    input  wire logic        clk_sys_i,
    // Device side of the pads.
    input  wire logic [11:0] pin_out_i,
    input  wire logic [11:0] pin_oe_i,
    input  wire logic [11:0] pin_pullup_i,
    // Bench-controlled external drivers.
    input  wire logic [11:0] ext_en_i,
    input  wire logic [11:0] ext_val_i,
    output logic      [11:0] pin_level_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic float_reg = 1'b0;

    // A floating pad toggles every cycle, so a released pin with no pull-up, other than the drain pin, never reads as a stable value.
    always @(posedge clk_sys_i) begin
        float_reg <= ~float_reg;
    end

    always_comb begin
        for (int i = 0; i < 12; i++) begin
            if (pin_oe_i[i]) begin
                pin_level_o[i] = pin_out_i[i];
            end else if (ext_en_i[i]) begin
                pin_level_o[i] = ext_val_i[i];
            end else if (i == 1) begin
                pin_level_o[i] = 1'b1;
            end else if (pin_pullup_i[i]) begin
                pin_level_o[i] = 1'b1;
            end else begin
                pin_level_o[i] = float_reg;
            end
        end
    end
endmodule // pin_board_model

// ===== sim/gpio_ports_with_open_drain_tb_top.sv
// Self-checking bench for the twelve-pin port block.
module gpio_ports_with_open_drain_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] ZERO_ADDRS [16] = '{8'hB8, 8'hC1, 8'hC2, 8'hC5, 8'hD0, 8'hD1,
        8'hD2, 8'hD5, 8'hE0, 8'hE1, 8'hE2, 8'hE5, 8'hE9, 8'hC8, 8'hC9, 8'h00};
    logic        clk_sys_i = 1'b0;
    logic        rstn_i = 1'b0;
    logic [7:0]  addr_i = 8'h00;
    logic [7:0]  wdata_i = 8'h00;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic [7:0]  rdata_o;
    logic [11:0] pin_in_i;
    logic [11:0] pin_out_o;
    logic [11:0] pin_oe_o;
    logic [11:0] pin_pullup_o;
    logic [11:0] ext_en = 12'hFFF;
    logic [11:0] ext_val = 12'h000;
    logic        ext_reset_sel_i = 1'b0;
    logic        bt_ovf = 1'b0;
    logic        pt_ovf = 1'b0;
    logic        pt_en = 1'b0;
    logic        pwm_sel = 1'b0;
    logic        tog_sel = 1'b0;
    logic        pwm_wave = 1'b1;
    logic        buz_wave = 1'b0;
    logic        ext_irq;
    logic        irq_o;
    logic [7:0]  d;
    int          n_errors = 0;
    int          n_compared = 0;
    int          cycles = 0;

    always #5 clk_sys_i = ~clk_sys_i;

    gpio_ports gpio_ports_inst (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pin_in_i(pin_in_i),
        .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o), .pin_pullup_o(pin_pullup_o),
        .ext_reset_sel_i(ext_reset_sel_i), .crystal_sel_i(1'b0), .basic_timer_ovf_i(bt_ovf),
        .pwm_timer_ovf_i(pt_ovf), .pwm_timer_enable_i(pt_en), .pwm_output_select_i(pwm_sel),
        .toggle_output_select_i(tog_sel), .pwm_wave_i(pwm_wave), .buzzer_wave_i(buz_wave),
        .external_interrupt_input_o(ext_irq), .irq_o(irq_o));

    pin_board_model pin_board_model_inst (.clk_sys_i(clk_sys_i), .pin_out_i(pin_out_o),
        .pin_oe_i(pin_oe_o), .pin_pullup_i(pin_pullup_o), .ext_en_i(ext_en),
        .ext_val_i(ext_val), .pin_level_o(pin_in_i));

    task automatic check(input logic [11:0] seen, input logic [11:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask

    // Whole-byte writes only, since several registers cannot be read back.
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_sys_i);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
        #1;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk_sys_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        #1;
        v = rdata_o;
    endtask

    task automatic t_reset();
        for (int i = 0; i < 16; i++) begin
            rd_reg(ZERO_ADDRS[i], d);
            check({4'h0, d}, 12'h000, "register after reset");
        end
        rd_reg(8'hBF, d);
        check({4'h0, d}, 12'h010, "edge field after reset");
        check(pin_oe_o, 12'h000, "drivers after reset");
        check(pin_pullup_o, 12'h000, "pull-ups after reset");
        $display("test reset done");
    endtask

    task automatic t_dir_pullup();
        wr_reg(8'hE0, 8'hFF);
        wr_reg(8'hE1, 8'hFF);
        wr_reg(8'hE2, 8'hFF);
        wr_reg(8'hE5, 8'hFF);
        check(pin_pullup_o, 12'hFFB, "pull-ups on inputs");
        wr_reg(8'hB8, 8'hFF);
        wr_reg(8'hC1, 8'hFF);
        wr_reg(8'hC2, 8'hFF);
        wr_reg(8'hC5, 8'hFF);
        check(pin_oe_o, 12'hFFB, "all outputs but input-only pin");
        check(pin_pullup_o, 12'h000, "pull-ups off for outputs");
        check(pin_out_o & 12'hFFB, 12'h000, "latch after reset");
        rd_reg(8'hB8, d);
        check({4'h0, d}, 12'h001, "port 0 direction");
        rd_reg(8'hC1, d);
        check({4'h0, d}, 12'h00D, "port 1 direction");
        wr_reg(8'hD2, 8'hFF);
        rd_reg(8'hD2, d);
        check({4'h0, d}, 12'h03F, "port 2 latch read");
        check(pin_out_o & 12'h7E0, 12'h7E0, "port 2 driven high");
        wr_reg(8'hD2, 8'h00);
        wr_reg(8'hB8, 8'h00);
        wr_reg(8'hC1, 8'h00);
        wr_reg(8'hC2, 8'h00);
        wr_reg(8'hC5, 8'h00);
        check(pin_oe_o, 12'h000, "back to inputs");
        check(pin_pullup_o, 12'hFFB, "pull-ups return");
        wr_reg(8'hE0, 8'h00);
        wr_reg(8'hE1, 8'h00);
        wr_reg(8'hE2, 8'h00);
        wr_reg(8'hE5, 8'h00);
        ext_val <= 12'h3A5;
        settle(4);
        rd_reg(8'hD2, d);
        check({4'h0, d}, {6'h00, 6'h1D}, "port 2 pin read");
        ext_val <= 12'h000;
        $display("test direction and pull-up done");
    endtask

    task automatic t_drain();
        // The bench lets go of the drain pin so only the board resistor can pull it high.
        ext_en[1] <= 1'b0;
        wr_reg(8'hD1, 8'h01);
        wr_reg(8'hC1, 8'h01);
        wr_reg(8'hE9, 8'h01);
        settle(4);
        check({pin_oe_o[1], pin_in_i[1]}, 12'h001, "drain released high");
        wr_reg(8'hD1, 8'h00);
        check({pin_oe_o[1], pin_out_o[1]}, 12'h002, "drain sinks low");
        wr_reg(8'hD1, 8'h01);
        wr_reg(8'hE9, 8'h00);
        check({pin_oe_o[1], pin_out_o[1]}, 12'h003, "push-pull high again");
        ext_en[1] <= 1'b1;
        $display("test open drain done");
    endtask

    task automatic t_reset_pin();
        ext_reset_sel_i <= 1'b1;
        settle(4);
        rd_reg(8'hD1, d);
        check({4'h0, d}, 12'h003, "reset-shared bit held at one");
        ext_reset_sel_i <= 1'b0;
        settle(4);
        rd_reg(8'hD1, d);
        check({4'h0, d}, 12'h001, "reset-shared bit follows pin");
        $display("test reset-shared pin done");
    endtask

    task automatic t_edges();
        for (int e = 0; e < 4; e++) begin
            wr_reg(8'hBF, 8'(e << 3));
            wr_reg(8'hC8, 8'hFF);
            ext_val[0] <= 1'b1;
            settle(5);
            rd_reg(8'hC8, d);
            check({4'h0, d}, {11'h000, e[0]}, "rising edge flag");
            wr_reg(8'hC8, 8'h01);
            ext_val[0] <= 1'b0;
            settle(5);
            rd_reg(8'hC8, d);
            check({4'h0, d}, {11'h000, e[1]}, "falling edge flag");
            check({11'h000, irq_o}, 12'h000, "masked flag quiet");
        end
        wr_reg(8'hC9, 8'h01);
        check({ext_irq, irq_o}, 12'h001, "unmasked flag raises request");
        wr_reg(8'hC8, 8'h01);
        check({11'h000, irq_o}, 12'h000, "flag cleared by one");
        ext_val[0] <= 1'b1;
        settle(4);
        check({ext_irq, irq_o}, 12'h003, "pin feeds external interrupt");
        wr_reg(8'hC9, 8'h00);
        wr_reg(8'hC8, 8'hFF);
        @(posedge clk_sys_i);
        bt_ovf <= 1'b1;
        @(posedge clk_sys_i);
        bt_ovf <= 1'b0;
        pt_ovf <= 1'b1;
        @(posedge clk_sys_i);
        pt_ovf <= 1'b0;
        rd_reg(8'hC8, d);
        check({4'h0, d}, 12'h030, "timer flags while disabled");
        $display("test interrupts done");
    endtask

    task automatic t_shared();
        wr_reg(8'hC5, 8'h10);
        check({pin_oe_o[11], pin_out_o[11]}, 12'h002, "port drives its latch");
        pt_en <= 1'b1;
        pwm_sel <= 1'b1;
        settle(1);
        check({pin_oe_o[11], pin_out_o[11]}, 12'h003, "wave output selected");
        pwm_sel <= 1'b0;
        tog_sel <= 1'b1;
        settle(1);
        check({11'h000, pin_out_o[11]}, 12'h000, "toggle output low");
        buz_wave <= 1'b1;
        settle(1);
        check({11'h000, pin_out_o[11]}, 12'h001, "toggle output high");
        pt_en <= 1'b0;
        settle(1);
        check({11'h000, pin_out_o[11]}, 12'h000, "latch back on pin");
        $display("test shared functions done");
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // The whole sequence needs well under a thousand cycles.
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            summarize();
        end
    end

    initial begin
        repeat (5) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        t_reset();
        t_dir_pullup();
        t_drain();
        t_reset_pin();
        t_edges();
        t_shared();
        summarize();
    end
endmodule // gpio_ports_with_open_drain_tb_top
